//--- src/mgae_flag.sv
`timescale 1ns/100ps
`default_nettype none
module mgae_flag #(
    parameter logic RST = 1'b0
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      q_o
);
    typedef struct packed {
        logic q;
    } mgae_flag_s;

    mgae_flag_s st_r;
    mgae_flag_s st_nxt;

    // Set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        st_nxt   = st_r;
        st_nxt.q = set_i | (st_r.q & ~clr_i);
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r.q <= RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.q;
endmodule : mgae_flag
`default_nettype wire

//--- src/mgae_pkg.sv
`default_nettype none
package mgae_pkg;

    localparam logic [4:0]  DEVAD            = 5'h07;

    localparam logic [15:0] ADDR_AN_CTRL     = 16'h0020;
    localparam logic [15:0] ADDR_AN_STAT     = 16'h0021;
    localparam logic [15:0] ADDR_EEE_ADV     = 16'h003c;
    localparam logic [15:0] ADDR_EEE_LP      = 16'h003d;
    localparam logic [15:0] ADDR_EEE_ADV2    = 16'h003e;
    localparam logic [15:0] ADDR_EEE_LP2     = 16'h003f;
    localparam logic [15:0] ADDR_PREC_CTRL   = 16'h0040;
    localparam logic [15:0] ADDR_PREC_STAT   = 16'h0041;

    localparam int BIT_LT_ADV          = 0;
    localparam int BIT_CFG_FAULT       = 15;
    localparam int BIT_ROLE            = 14;
    localparam int BIT_LOCAL_RX        = 13;
    localparam int BIT_REMOTE_RX       = 12;
    localparam int BIT_LP_TEN          = 11;
    localparam int BIT_LP_LOOP         = 10;
    localparam int BIT_LP_TRAIN        = 9;
    localparam int BIT_LP_FIVE         = 6;
    localparam int BIT_LP_TWO_HALF     = 5;
    localparam int BIT_FR_FIVE         = 4;
    localparam int BIT_FR_TWO_HALF     = 3;
    localparam int BIT_FR_TEN          = 1;
    localparam int EEE_MSB             = 6;
    localparam int EEE_LSB             = 1;
    localparam int BIT_EEE_FIVE        = 1;
    localparam int BIT_EEE_TWO_HALF    = 0;
    localparam int BIT_PREC_TWO_HALF   = 3;
    localparam int BIT_PREC_FIVE       = 2;

    localparam logic       RST_LT_ADV    = 1'b1;
    localparam logic       RST_CFG_FAULT = 1'b0;
    localparam logic [5:0] RST_EEE_ADV   = 6'h07;
    localparam logic [1:0] RST_EEE_ADV2  = 2'h0;
    localparam logic [1:0] RST_PREC_REQ  = 2'h0;

    localparam logic [5:0] PRE_ONES      = 6'h20;
    localparam logic [4:0] HDR_LAST      = 5'h0c;
    localparam logic [4:0] DATA_LAST     = 5'h0f;
    localparam logic [1:0] OP_ADDR       = 2'h0;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [1:0] OP_READ_INC   = 2'h2;
    localparam logic [1:0] OP_READ       = 2'h3;

    typedef enum logic [1:0] {MS_PRE, MS_HDR, MS_TA, MS_DATA} mgae_mdio_e;

    typedef struct packed {
        logic       ten_gig_able;
        logic       loop_timing_able;
        logic       training_reset_req;
        logic       five_gig_able;
        logic       two_half_gig_able;
        logic       fast_retrain_five;
        logic       fast_retrain_two_half;
        logic       fast_retrain_ten;
        logic [5:0] eee;
        logic       eee_five;
        logic       eee_two_half;
        logic       precoder_req_two_half;
        logic       precoder_req_five;
    } mgae_partner_s;

    typedef struct packed {
        logic role_resolved;
        logic local_rx_ok;
        logic remote_rx_ok;
        logic cfg_fault;
        logic loop_timing_able;
    } mgae_link_s;

    typedef struct packed {
        logic [5:0] eee_adv;
        logic       eee_five_adv;
        logic       eee_two_half_adv;
        logic       precoder_req_two_half;
        logic       precoder_req_five;
        logic       loop_timing_adv;
    } mgae_local_s;

    typedef struct packed {
        logic mdc;
        logic mdio;
    } mgae_pins_s;

endpackage : mgae_pkg
`default_nettype wire

//--- src/mgae_regs.sv
`timescale 1ns/100ps
`default_nettype none
module mgae_regs #(
    parameter logic [4:0] PORT_ADDR = 5'h00
) (
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   mdc_i,
    input  wire logic                   mdio_i,
    output logic                        mdio_o,
    output logic                        mdio_oe_o,
    input  wire logic                   page_valid_i,
    input  wire mgae_pkg::mgae_partner_s partner_i,
    input  wire mgae_pkg::mgae_link_s    link_i,
    output mgae_pkg::mgae_local_s        local_adv_o
);
    typedef struct packed {
        mgae_pkg::mgae_mdio_e    state;
        logic [4:0]              cnt;
        logic [5:0]              pre;
        logic [15:0]             sh;
        logic [1:0]              op;
        logic                    match;
        logic [15:0]             addr;
        logic                    mdc_d;
        logic                    mdio_o;
        logic                    mdio_oe;
        mgae_pkg::mgae_partner_s partner;
        logic [5:0]              eee_adv;
        logic [1:0]              eee_adv2;
        logic [1:0]              prec_req;
    } mgae_regs_s;

    mgae_regs_s          st_r;
    mgae_regs_s          st_nxt;
    mgae_pkg::mgae_pins_s pins_s;
    logic                lt_q;
    logic                fault_q;
    logic                rd_an_ctrl;
    logic                rd_an_stat;
    logic                mdc_rise;
    logic [15:0]         rdata;
    logic [15:0]         wdata;
    logic [12:0]         hdr;

    // Pins are asynchronous to clock_i; MDC must stay well below clock_i/8
    mgae_sync #(
        .W(2)
    ) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .d_i    ({mdc_i, mdio_i}),
        .q_o    (pins_s)
    );

    mgae_flag #(
        .RST(mgae_pkg::RST_LT_ADV)
    ) u_lt_flag (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .set_i  (link_i.loop_timing_able),
        .clr_i  (rd_an_ctrl),
        .q_o    (lt_q)
    );

    mgae_flag #(
        .RST(mgae_pkg::RST_CFG_FAULT)
    ) u_fault_flag (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .set_i  (link_i.cfg_fault),
        .clr_i  (rd_an_stat),
        .q_o    (fault_q)
    );

    always_comb begin
        st_nxt     = st_r;
        rd_an_ctrl = 1'b0;
        rd_an_stat = 1'b0;
        mdc_rise   = pins_s.mdc & ~st_r.mdc_d;
        wdata      = {st_r.sh[14:0], pins_s.mdio};
        hdr        = {st_r.sh[11:0], pins_s.mdio};
        st_nxt.mdc_d = pins_s.mdc;

        // Read view; unlisted and reserved bits stay zero
        rdata = 16'h0000;
        case (st_r.addr)
            mgae_pkg::ADDR_AN_CTRL: begin
                rdata[mgae_pkg::BIT_LT_ADV] = lt_q;
            end
            mgae_pkg::ADDR_AN_STAT: begin
                rdata[mgae_pkg::BIT_CFG_FAULT]   = fault_q;
                rdata[mgae_pkg::BIT_ROLE]        = link_i.role_resolved;
                rdata[mgae_pkg::BIT_LOCAL_RX]    = link_i.local_rx_ok;
                rdata[mgae_pkg::BIT_REMOTE_RX]   = link_i.remote_rx_ok;
                rdata[mgae_pkg::BIT_LP_TEN]      = st_r.partner.ten_gig_able;
                rdata[mgae_pkg::BIT_LP_LOOP]     = st_r.partner.loop_timing_able;
                rdata[mgae_pkg::BIT_LP_TRAIN]    = st_r.partner.training_reset_req;
                rdata[mgae_pkg::BIT_LP_FIVE]     = st_r.partner.five_gig_able;
                rdata[mgae_pkg::BIT_LP_TWO_HALF] = st_r.partner.two_half_gig_able;
                rdata[mgae_pkg::BIT_FR_FIVE]     = st_r.partner.fast_retrain_five;
                rdata[mgae_pkg::BIT_FR_TWO_HALF] = st_r.partner.fast_retrain_two_half;
                rdata[mgae_pkg::BIT_FR_TEN]      = st_r.partner.fast_retrain_ten;
            end
            mgae_pkg::ADDR_EEE_ADV: begin
                rdata[mgae_pkg::EEE_MSB:mgae_pkg::EEE_LSB] = st_r.eee_adv;
            end
            mgae_pkg::ADDR_EEE_LP: begin
                rdata[mgae_pkg::EEE_MSB:mgae_pkg::EEE_LSB] = st_r.partner.eee;
            end
            mgae_pkg::ADDR_EEE_ADV2: begin
                rdata[1:0] = st_r.eee_adv2;
            end
            mgae_pkg::ADDR_EEE_LP2: begin
                rdata[mgae_pkg::BIT_EEE_FIVE]     = st_r.partner.eee_five;
                rdata[mgae_pkg::BIT_EEE_TWO_HALF] = st_r.partner.eee_two_half;
            end
            mgae_pkg::ADDR_PREC_CTRL: begin
                rdata[3:2] = st_r.prec_req;
            end
            mgae_pkg::ADDR_PREC_STAT: begin
                rdata[mgae_pkg::BIT_PREC_TWO_HALF] = st_r.partner.precoder_req_two_half;
                rdata[mgae_pkg::BIT_PREC_FIVE]     = st_r.partner.precoder_req_five;
            end
            default: begin
                rdata = 16'h0000;
            end
        endcase

        // Partner fields follow each received page as a whole
        if (page_valid_i) begin
            st_nxt.partner = partner_i;
        end

        if (mdc_rise) begin
            case (st_r.state)
                mgae_pkg::MS_PRE: begin
                    st_nxt.mdio_oe = 1'b0;
                    if (pins_s.mdio) begin
                        if (st_r.pre != mgae_pkg::PRE_ONES) begin
                            st_nxt.pre = st_r.pre + 6'h01;
                        end
                    end else if (st_r.pre == mgae_pkg::PRE_ONES) begin
                        st_nxt.state = mgae_pkg::MS_HDR;
                        st_nxt.cnt   = 5'h00;
                    end else begin
                        st_nxt.pre = 6'h00;
                    end
                end
                mgae_pkg::MS_HDR: begin
                    st_nxt.sh  = wdata;
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.cnt == mgae_pkg::HDR_LAST) begin
                        // hdr: second start bit, opcode, port, device
                        st_nxt.op    = hdr[11:10];
                        st_nxt.match = ~hdr[12] && (hdr[9:5] == PORT_ADDR)
                                       && (hdr[4:0] == mgae_pkg::DEVAD);
                        st_nxt.state = mgae_pkg::MS_TA;
                        st_nxt.cnt   = 5'h00;
                    end
                end
                mgae_pkg::MS_TA: begin
                    if (st_r.cnt == 5'h00) begin
                        st_nxt.cnt = 5'h01;
                        if (st_r.match && st_r.op[1]) begin
                            st_nxt.mdio_oe = 1'b1;
                            st_nxt.mdio_o  = 1'b0;
                        end
                    end else begin
                        st_nxt.state = mgae_pkg::MS_DATA;
                        st_nxt.cnt   = 5'h00;
                        if (st_r.match && st_r.op[1]) begin
                            st_nxt.mdio_o = rdata[15];
                            st_nxt.sh     = {rdata[14:0], 1'b0};
                            // Latched bits clear when their word is read
                            rd_an_ctrl = (st_r.addr == mgae_pkg::ADDR_AN_CTRL);
                            rd_an_stat = (st_r.addr == mgae_pkg::ADDR_AN_STAT);
                            if (st_r.op == mgae_pkg::OP_READ_INC) begin
                                st_nxt.addr = st_r.addr + 16'h0001;
                            end
                        end
                    end
                end
                mgae_pkg::MS_DATA: begin
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.op[1]) begin
                        st_nxt.mdio_o = st_r.sh[15];
                        st_nxt.sh     = {st_r.sh[14:0], 1'b0};
                    end else begin
                        st_nxt.sh = wdata;
                    end
                    if (st_r.cnt == mgae_pkg::DATA_LAST) begin
                        st_nxt.state   = mgae_pkg::MS_PRE;
                        st_nxt.pre     = 6'h00;
                        st_nxt.mdio_oe = 1'b0;
                        st_nxt.mdio_o  = 1'b0;
                        if (st_r.match && (st_r.op == mgae_pkg::OP_ADDR)) begin
                            st_nxt.addr = wdata;
                        end
                        if (st_r.match && (st_r.op == mgae_pkg::OP_WRITE)) begin
                            // Only writable fields take data
                            case (st_r.addr)
                                mgae_pkg::ADDR_EEE_ADV: begin
                                    st_nxt.eee_adv =
                                        wdata[mgae_pkg::EEE_MSB:mgae_pkg::EEE_LSB];
                                end
                                mgae_pkg::ADDR_EEE_ADV2: begin
                                    st_nxt.eee_adv2 = wdata[1:0];
                                end
                                mgae_pkg::ADDR_PREC_CTRL: begin
                                    st_nxt.prec_req = wdata[3:2];
                                end
                                default: begin
                                    st_nxt.eee_adv = st_r.eee_adv;
                                end
                            endcase
                        end
                    end
                end
                default: begin
                    st_nxt.state   = mgae_pkg::MS_PRE;
                    st_nxt.mdio_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r          <= '0;
            st_r.state    <= mgae_pkg::MS_PRE;
            st_r.mdc_d    <= 1'b1;
            st_r.eee_adv  <= mgae_pkg::RST_EEE_ADV;
            st_r.eee_adv2 <= mgae_pkg::RST_EEE_ADV2;
            st_r.prec_req <= mgae_pkg::RST_PREC_REQ;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mdio_o    = st_r.mdio_o;
    assign mdio_oe_o = st_r.mdio_oe;

    // Advertised fields go to the engine for its next outgoing pages
    assign local_adv_o.eee_adv               = st_r.eee_adv;
    assign local_adv_o.eee_five_adv          = st_r.eee_adv2[mgae_pkg::BIT_EEE_FIVE];
    assign local_adv_o.eee_two_half_adv      = st_r.eee_adv2[mgae_pkg::BIT_EEE_TWO_HALF];
    assign local_adv_o.precoder_req_two_half = st_r.prec_req[1];
    assign local_adv_o.precoder_req_five     = st_r.prec_req[0];
    assign local_adv_o.loop_timing_adv       = lt_q;
endmodule : mgae_regs
`default_nettype wire

//--- src/mgae_sync.sv
`timescale 1ns/100ps
`default_nettype none
module mgae_sync #(
    parameter int W = 2
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mgae_sync_s;

    mgae_sync_s st_r;
    mgae_sync_s st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.s2;
endmodule : mgae_sync
`default_nettype wire

//--- testbench/mgae_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module mgae_host_model (
    input  wire logic            clock_i,
    input  wire logic            line_i,
    output mgae_pkg::mgae_pins_s pins_o,
    output logic                 drive_o
);
    initial begin
        pins_o  = '{mdc: 1'b0, mdio: 1'b1};
        drive_o = 1'b0;
    end

    // Ten clocks per bit; data moves only while MDC is low, sampled at the rise
    task automatic bit_cycle(input logic en, input logic d, output logic s);
        drive_o     = en;
        pins_o.mdio = d;
        repeat (5) @(negedge clock_i);
        pins_o.mdc = 1'b1;
        s = line_i;
        repeat (5) @(negedge clock_i);
        pins_o.mdc = 1'b0;
    endtask : bit_cycle

    // Full frame each time: the device wants the preamble before every frame
    task automatic xfer(input logic [1:0] op, input logic [4:0] port, input logic [4:0] dev,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic        s;
        logic [13:0] hdr;
        hdr = {2'b00, op, port, dev};
        rd  = 16'h0000;
        for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
        bit_cycle(~op[1], 1'b1, s);
        bit_cycle(~op[1], 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(~op[1], wd[i], s);
            rd[i] = s;
        end
        drive_o = 1'b0;
    endtask : xfer
endmodule : mgae_host_model
`default_nettype wire

//--- testbench/mgae_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module mgae_regs_asserts (
    input wire logic                    clock_i,
    input wire logic                    rst_n_i,
    input wire logic                    mdc_i,
    input wire logic                    mdio_i,
    input wire logic                    mdio_o,
    input wire logic                    mdio_oe_o,
    input wire logic                    page_valid_i,
    input wire mgae_pkg::mgae_partner_s partner_i,
    input wire mgae_pkg::mgae_link_s    link_i,
    input wire mgae_pkg::mgae_local_s   local_adv_o
);
    default clocking cb @(posedge clock_i); endclocking

    // Reset checks carry no disable: they look at the edge after reset
    a_lt_reset: assert property (!rst_n_i |=> local_adv_o.loop_timing_adv)
        else $error("loop-timing advert not set by reset");
    a_lt_set: assert property (disable iff (!rst_n_i)
        link_i.loop_timing_able |=> local_adv_o.loop_timing_adv)
        else $error("loop-timing advert not latched");
    a_lt_read_clear: assert property (disable iff (!rst_n_i)
        $fell(local_adv_o.loop_timing_adv) |-> mdio_oe_o)
        else $error("loop-timing advert cleared outside a read");
    a_eee_reset: assert property (!rst_n_i |=> local_adv_o.eee_adv == 6'h07)
        else $error("eee advert reset value wrong");
    a_eee_two_reset: assert property (!rst_n_i |=>
        {local_adv_o.eee_five_adv, local_adv_o.eee_two_half_adv} == 2'b00)
        else $error("second eee advert reset value wrong");
    a_prec_reset: assert property (!rst_n_i |=>
        {local_adv_o.precoder_req_two_half, local_adv_o.precoder_req_five} == 2'b00)
        else $error("precoder request reset value wrong");
    a_eee_write_only: assert property (disable iff (!rst_n_i)
        $changed(local_adv_o.eee_adv) |-> !mdio_oe_o)
        else $error("eee advert changed during a read");
    a_req_write_only: assert property (disable iff (!rst_n_i)
        $changed({local_adv_o.eee_five_adv, local_adv_o.eee_two_half_adv,
                  local_adv_o.precoder_req_two_half, local_adv_o.precoder_req_five})
        |-> !mdio_oe_o)
        else $error("request bits changed during a read");
    a_read_lead: assert property (disable iff (!rst_n_i)
        $rose(mdio_oe_o) |-> !mdio_o ##1 mdio_oe_o [*8])
        else $error("read turnaround malformed");

    cover property (disable iff (!rst_n_i) $rose(mdio_oe_o));
    cover property (disable iff (!rst_n_i) $fell(local_adv_o.loop_timing_adv));
    cover property (disable iff (!rst_n_i) $changed(local_adv_o.eee_adv));
    cover property (disable iff (!rst_n_i) page_valid_i);
endmodule : mgae_regs_asserts

bind mgae_regs mgae_regs_asserts u_asserts (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .mdc_i(mdc_i), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .page_valid_i(page_valid_i),
    .partner_i(partner_i), .link_i(link_i), .local_adv_o(local_adv_o)
);
`default_nettype wire

//--- testbench/mgae_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mgae_regs_tb;
    localparam logic [4:0] PORT = 5'h05;
    logic                    clock_i, rst_n_i, page_valid_i, line, host_en, mdio_o, mdio_oe_o;
    mgae_pkg::mgae_partner_s partner_i;
    mgae_pkg::mgae_link_s    link_i;
    mgae_pkg::mgae_local_s   local_adv_o;
    mgae_pkg::mgae_pins_s    pins;
    int                      error_cnt, n_checks, m_lt, m_fault, m_lk;
    int                      m_reg[int];
    int                      addrs[9] = '{'h20, 'h21, 'h3c, 'h3d, 'h3e, 'h3f, 'h40, 'h41, 'h22};
    logic [15:0]             d;

    // Open-drain style line with a pull-up: nobody driving reads as one
    assign line = mdio_oe_o ? mdio_o : (host_en ? pins.mdio : 1'b1);

    mgae_regs #(.PORT_ADDR(PORT)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .mdc_i(pins.mdc), .mdio_i(line),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .page_valid_i(page_valid_i),
        .partner_i(partner_i), .link_i(link_i), .local_adv_o(local_adv_o));
    mgae_host_model host (.clock_i(clock_i), .line_i(line), .pins_o(pins), .drive_o(host_en));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [15:0] exp_of(input int a);
        case (a)
            'h20:    return 16'(m_lt);
            'h21:    return 16'((m_fault << 15) | (m_lk << 12) | m_reg['h21]);
            default: return m_reg.exists(a) ? 16'(m_reg[a]) : 16'h0000;
        endcase
    endfunction : exp_of

    function automatic int wmask(input int a);
        case (a)
            'h3c:    return 'h7e;
            'h3e:    return 'h03;
            'h40:    return 'h0c;
            default: return 0;
        endcase
    endfunction : wmask

    function automatic logic [10:0] exp_local();
        logic [15:0] a, b, c;
        a = 16'(m_reg['h3c]);
        b = 16'(m_reg['h3e]);
        c = 16'(m_reg['h40]);
        return {a[6:1], b[1:0], c[3], c[2], m_lt[0]};
    endfunction : exp_local

    task automatic rd_reg(input int a);
        logic [15:0] rd, e;
        host.xfer(mgae_pkg::OP_ADDR, PORT, mgae_pkg::DEVAD, 16'(a), rd);
        e = exp_of(a);
        host.xfer(mgae_pkg::OP_READ, PORT, mgae_pkg::DEVAD, 16'h0000, rd);
        chk(rd, e);
        if (a == 'h20) m_lt = 0;
        if (a == 'h21) m_fault = 0;
    endtask : rd_reg

    task automatic wr_reg(input int a, input logic [15:0] v);
        logic [15:0] rd;
        host.xfer(mgae_pkg::OP_ADDR, PORT, mgae_pkg::DEVAD, 16'(a), rd);
        host.xfer(mgae_pkg::OP_WRITE, PORT, mgae_pkg::DEVAD, v, rd);
        if (m_reg.exists(a)) m_reg[a] = (m_reg[a] & ~wmask(a)) | (int'(v) & wmask(a));
    endtask : wr_reg

    // Bus is scrambled right after the capture edge so a late capture shows
    task automatic page();
        logic [17:0] pv;
        pv = 18'($urandom);
        @(negedge clock_i);
        partner_i    = pv;
        page_valid_i = 1'b1;
        @(negedge clock_i);
        page_valid_i = 1'b0;
        partner_i    = ~pv;
        m_reg['h21]  = int'({pv[17:15], 2'b00, pv[14:11], 1'b0, pv[10], 1'b0});
        m_reg['h3d]  = int'({pv[9:4], 1'b0});
        m_reg['h3f]  = int'(pv[3:2]);
        m_reg['h41]  = int'({pv[1:0], 2'b00});
    endtask : page

    initial begin
        repeat (90000) @(posedge clock_i);
        error_cnt++;
        $display("[ERR] %0t ns: run limit reached", $time);
        close_out();
    end

    initial begin
        rst_n_i = 1'b0;
        page_valid_i = 1'b0;
        partner_i = '0;
        link_i = '0;
        error_cnt = 0;
        n_checks = 0;
        m_lt = 1;
        m_fault = 0;
        m_lk = 0;
        m_reg = '{'h21: 0, 'h3c: 'h0e, 'h3d: 0, 'h3e: 0, 'h3f: 0, 'h40: 0, 'h41: 0};
        void'($urandom(16));
        repeat (3) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        foreach (addrs[i]) rd_reg(addrs[i]);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            wr_reg(addrs[i], 16'hffff);
            rd_reg(addrs[i]);
            wr_reg(addrs[i], 16'($urandom));
            rd_reg(addrs[i]);
            chk(16'(local_adv_o), 16'(exp_local()));
        end
        $display("write access done");
        repeat (2) begin
            page();
            foreach (addrs[i]) if (addrs[i] != 'h20) rd_reg(addrs[i]);
        end
        $display("partner pages done");
        m_lk = $urandom_range(7, 0);
        @(negedge clock_i);
        link_i = {3'(m_lk), 2'b10};
        @(negedge clock_i);
        link_i.cfg_fault = 1'b0;
        m_fault = 1;
        rd_reg('h21);
        rd_reg('h21);
        link_i.loop_timing_able = 1'b1;
        @(negedge clock_i);
        link_i.loop_timing_able = 1'b0;
        m_lt = 1;
        rd_reg('h20);
        rd_reg('h20);
        $display("latched flags done");
        host.xfer(mgae_pkg::OP_ADDR, PORT, 5'h03, 16'h003c, d);
        host.xfer(mgae_pkg::OP_WRITE, PORT, 5'h03, 16'h0000, d);
        rd_reg('h3c);
        host.xfer(mgae_pkg::OP_READ, PORT ^ 5'h01, mgae_pkg::DEVAD, 16'h0000, d);
        chk(d, 16'hffff);
        chk(16'(local_adv_o), 16'(exp_local()));
        $display("refused frames done");
        close_out();
    end
endmodule : mgae_regs_tb
`default_nettype wire
